//--- core/qubp_pkg.sv
// Shared constants and carrier types for the quad channel host bus port
package qubp_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHAN     = 4;
  localparam int unsigned REG_AW       = 3;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned REGS_PER_CH  = 8;
  localparam int unsigned CHAN_AW      = 2;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned NUM_TRIG     = 4;

  // ----------------------------------------------------------------
  // Register offsets inside one channel
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA    = 3'h0;
  localparam logic [2:0] OFS_FCTL    = 3'h2;
  localparam logic [2:0] OFS_MCTL    = 3'h4;
  localparam logic [2:0] OFS_STAT    = 3'h5;

  // Field positions
  localparam int unsigned MCTL_IRQ_EN_BIT = 3;
  localparam int unsigned FCTL_TRIG_LSB   = 6;
  localparam int unsigned STAT_RXRDY_BIT  = 0;
  localparam int unsigned STAT_TXEMP_BIT  = 5;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;

  // Receive fill thresholds selected by the trigger field
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0E;

  typedef enum logic {BUS_RW, BUS_STROBE} qubp_style_t;

  // Host-side control pins as they arrive
  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic [3:0] sel_n;
  } qubp_ctl_t;
endpackage

//--- core/qubp_mem.sv
// Small register memory: eight bytes per channel, registered read data
`timescale 1ns/1ns
module qubp_mem #(
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 8
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  // Read port
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_q[raddr_in];
    end
  end
endmodule // qubp_mem

//--- core/qubp_port.sv
// Host bus port of a four channel serial controller
// How it works
// R1 - Four channels, each own register set
// R2 - Three address lines pick channel register
// R3 - Eight-bit data bus, driven only during reads
// R4 - Style pin high strobe style, low read/write
// R5 - Read strobe fall starts read, byte driven
// R6 - Read/write style ignores read strobe
// R7 - Write strobe rise loads bus byte
// R8 - Read/write style: direction level high read
// R9 - Strobe style: four selects, one per channel
// R10 - Read/write style: first select is device select
// R11 - Read/write style: two selects become address
// R12 - Read/write style ignores fourth select
// R13 - Sixteen byte queues, received bytes tagged
// R14 - Four receive fill thresholds, software chosen
// R15 - Strobe style irq driven when enable bit set
// R16 - Read/write style: one open-drain irq, rest low
// R17 - Extra address decoded binary to channel
`timescale 1ns/1ns
module qubp_port #(
  parameter int unsigned NUM_CHAN = qubp_pkg::NUM_CHAN,
  parameter int unsigned DEPTH    = qubp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       CORE_CLK_IN,
  input  wire logic       NRST_IN,
  // Bus style strap
  input  wire logic       BUS_STYLE_IN,
  // Host control and address
  input  wire logic       HOST_READ_STROBE_N_IN,
  input  wire logic       HOST_WRITE_STROBE_N_IN,
  input  wire logic       CHAN_A_SELECT_N_IN,
  input  wire logic       CHAN_B_SELECT_N_IN,
  input  wire logic       CHAN_C_SELECT_N_IN,
  input  wire logic       CHAN_D_SELECT_N_IN,
  input  wire logic [2:0] REG_ADDR_IN,
  // Data bus
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE_OUT,
  // Receive side feed and transmit pops from the serial cores
  input  wire logic [3:0] RX_PUSH_IN,
  input  wire logic [7:0] RX_BYTE_IN,
  input  wire logic [2:0] RX_TAG_IN,
  input  wire logic [3:0] TX_POP_IN,
  // Interrupt sources and pins
  input  wire logic [3:0] IRQ_SRC_IN,
  output logic      [3:0] IRQ_OUT,
  output logic      [3:0] IRQ_OE_OUT
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial begin
    if (NUM_CHAN != 4 || DEPTH < 2 || DEPTH > 16) begin
      $error("qubp_port: unsupported NUM_CHAN or DEPTH");
    end
  end

  localparam int unsigned CW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] onehot2(input logic [1:0] n);
    onehot2 = 4'h1 << n;
  endfunction

  qubp_pkg::qubp_ctl_t ctl;
  qubp_pkg::qubp_style_t style;
  logic [3:0] chan_hit;
  logic       rd_act;
  logic       wr_act;
  logic [1:0] chan_num;

  assign ctl.rd_n  = HOST_READ_STROBE_N_IN;
  assign ctl.wr_n  = HOST_WRITE_STROBE_N_IN;
  assign ctl.sel_n = {CHAN_D_SELECT_N_IN, CHAN_C_SELECT_N_IN,
                      CHAN_B_SELECT_N_IN, CHAN_A_SELECT_N_IN};
  assign style = BUS_STYLE_IN ? qubp_pkg::BUS_STROBE
                              : qubp_pkg::BUS_RW; // [R4]

  always_comb begin
    chan_hit = 4'h0;
    rd_act   = 1'b0;
    wr_act   = 1'b0;
    chan_num = 2'h0;
    if (style == qubp_pkg::BUS_STROBE) begin
      chan_hit = ~ctl.sel_n; // [R9]
      if (ctl.sel_n[3:1] == 3'h7) chan_num = 2'h0;
      else if (ctl.sel_n[1] == 1'b0) chan_num = 2'h1;
      else if (ctl.sel_n[2] == 1'b0) chan_num = 2'h2;
      else chan_num = 2'h3;
      // Several selects low at once is a host fault; lowest wins
      if (!ctl.sel_n[0]) chan_num = 2'h0;
      rd_act = !ctl.rd_n && (ctl.sel_n != 4'hF); // [R5]
      wr_act = !ctl.wr_n && (ctl.sel_n != 4'hF); // [R7]
    end else begin
      // Fourth select and read strobe are not looked at here
      chan_num = {ctl.sel_n[2], ctl.sel_n[1]}; // [R11] [R17] [R6] [R12]
      chan_hit = ctl.sel_n[0] ? 4'h0 : onehot2(chan_num); // [R10]
      rd_act = !ctl.sel_n[0] && ctl.wr_n;  // [R8]
      wr_act = !ctl.sel_n[0] && !ctl.wr_n; // [R8]
    end
  end

  // ----------------------------------------------------------------
  // Edge detection on the access levels
  // ----------------------------------------------------------------
  logic       rd_q;
  logic       wr_q;
  logic [4:0] waddr_q;
  logic [7:0] wdata_q;
  logic       rd_start;
  logic       wr_done;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= rd_act;
      wr_q <= wr_act;
    end
  end

  // Address and data tracked while the write is open; loaded at its end
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      waddr_q <= 5'h00;
      wdata_q <= 8'h00;
    end else if (wr_act) begin
      waddr_q <= {chan_num, REG_ADDR_IN}; // [R2]
      wdata_q <= DATA_IN;
    end
  end

  assign rd_start = rd_act && !rd_q; // [R5]
  assign wr_done  = wr_q && !wr_act; // [R7]

  // ----------------------------------------------------------------
  // Register storage for all channels
  // ----------------------------------------------------------------
  logic [7:0] mem_rdata;

  qubp_mem #(.AW(5), .DW(8)) u_mem (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (NRST_IN),
    .we_in     (wr_done),
    .waddr_in  (waddr_q),
    .wdata_in  (wdata_q),
    .raddr_in  ({chan_num, REG_ADDR_IN}),
    .rdata_out (mem_rdata)
  ); // [R1]

  // ----------------------------------------------------------------
  // Per channel queues, control bits and interrupt pins
  // ----------------------------------------------------------------
  logic [3:0]    irq_en_q;
  logic [1:0]    trig_q   [4];
  logic [CW-1:0] rx_cnt_q [4];
  logic [CW-1:0] tx_cnt_q [4];
  logic [10:0]   rx_head_q[4];
  logic [3:0]    rx_ready;
  logic [3:0]    rx_pop;

  function automatic logic [4:0] trig_lvl(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_lvl = qubp_pkg::TRIG_LVL0;
      2'h1: trig_lvl = qubp_pkg::TRIG_LVL1;
      2'h2: trig_lvl = qubp_pkg::TRIG_LVL2;
      2'h3: trig_lvl = qubp_pkg::TRIG_LVL3;
    endcase
  endfunction

  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_chan
      logic hit_wr;
      logic tx_push;
      logic en_q;
      // One process per channel owns its enable bit
      assign irq_en_q[c] = en_q;
      assign hit_wr  = wr_done && (waddr_q[4:3] == 2'(c));
      assign tx_push = hit_wr && (waddr_q[2:0] == qubp_pkg::OFS_DATA)
                       && (tx_cnt_q[c] != CW'(DEPTH));
      assign rx_pop[c] = rd_start && chan_hit[c]
                         && (REG_ADDR_IN == qubp_pkg::OFS_DATA)
                         && (rx_cnt_q[c] != '0);

      always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          en_q      <= 1'b0;
          trig_q[c] <= 2'h0;
        end else if (hit_wr && waddr_q[2:0] == qubp_pkg::OFS_MCTL) begin
          en_q <= wdata_q[qubp_pkg::MCTL_IRQ_EN_BIT]; // [R15]
        end else if (hit_wr && waddr_q[2:0] == qubp_pkg::OFS_FCTL) begin
          trig_q[c] <= wdata_q[qubp_pkg::FCTL_TRIG_LSB +: 2]; // [R14]
        end
      end

      // Occupancy counts; storage of queued bytes lives in the cores
      always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          rx_cnt_q[c] <= '0;
        end else if ((RX_PUSH_IN[c] && rx_cnt_q[c] != CW'(DEPTH))
                     && !rx_pop[c]) begin
          rx_cnt_q[c] <= rx_cnt_q[c] + 1'b1; // [R13]
        end else if (rx_pop[c] && !RX_PUSH_IN[c]) begin
          rx_cnt_q[c] <= rx_cnt_q[c] - 1'b1;
        end
      end

      always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          tx_cnt_q[c] <= '0;
        end else if (tx_push && !(TX_POP_IN[c] && tx_cnt_q[c] != '0)) begin
          tx_cnt_q[c] <= tx_cnt_q[c] + 1'b1; // [R13]
        end else if (!tx_push && TX_POP_IN[c] && tx_cnt_q[c] != '0) begin
          tx_cnt_q[c] <= tx_cnt_q[c] - 1'b1;
        end
      end

      // Latest received byte with its error tag
      always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          rx_head_q[c] <= 11'h000;
        end else if (RX_PUSH_IN[c]) begin
          rx_head_q[c] <= {RX_TAG_IN, RX_BYTE_IN}; // [R13]
        end
      end

      assign rx_ready[c] = 5'(rx_cnt_q[c])
                           >= trig_lvl(trig_q[c]); // [R14]
    end
  endgenerate

  // Interrupt pins: strobe style per channel, else one open drain line
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      IRQ_OUT    <= 4'h0;
      IRQ_OE_OUT <= 4'h0;
    end else if (style == qubp_pkg::BUS_STROBE) begin
      IRQ_OUT    <= IRQ_SRC_IN;
      IRQ_OE_OUT <= irq_en_q; // [R15]
    end else begin
      IRQ_OUT    <= 4'h0; // [R16]
      IRQ_OE_OUT <= {3'h7, |IRQ_SRC_IN}; // [R16]
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  logic [1:0] rd_chan_q;
  logic [2:0] rd_reg_q;
  logic       rd_pend_q;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_chan_q <= 2'h0;
      rd_reg_q  <= 3'h0;
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_start;
      if (rd_start) begin
        rd_chan_q <= chan_num;
        rd_reg_q  <= REG_ADDR_IN; // [R2]
      end
    end
  end

  // Byte is captured on the second edge after the fall and held until release
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      DATA_OUT <= qubp_pkg::REG_RST;
    end else if (rd_pend_q) begin
      unique case (rd_reg_q)
        qubp_pkg::OFS_DATA: DATA_OUT <= rx_head_q[rd_chan_q][7:0];
        qubp_pkg::OFS_STAT: DATA_OUT <= {2'h0,
          tx_cnt_q[rd_chan_q] == '0, 4'h0, rx_ready[rd_chan_q]}; // [R5]
        default:            DATA_OUT <= mem_rdata;
      endcase
    end
  end

  assign DATA_OE_OUT = rd_act && rd_q; // [R3]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  data_oe_rd_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    DATA_OE_OUT |-> rd_act) else $error("data driven outside read"); // [R3]
  no_oe_wr_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    wr_act |-> !DATA_OE_OUT) else $error("data driven on write"); // [R3]
  rd_start_oe_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    rd_start ##1 rd_act |-> DATA_OE_OUT) else $error("read not driven"); // [R5]
  wr_load_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    $fell(wr_act) |-> wr_done) else $error("write not loaded"); // [R7]
  rw_dir_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (!BUS_STYLE_IN && !CHAN_A_SELECT_N_IN) |-> (rd_act == HOST_WRITE_STROBE_N_IN)
  ) else $error("direction level wrong"); // [R8]
  strobe_sel_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    BUS_STYLE_IN |-> chan_hit == ~ctl.sel_n) else $error("select map"); // [R9]
  rw_chan_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (!BUS_STYLE_IN && !CHAN_A_SELECT_N_IN) |->
    chan_hit == onehot2({CHAN_C_SELECT_N_IN, CHAN_B_SELECT_N_IN}))
    else $error("channel decode wrong"); // [R17]
  irq_en_pin_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    $past(BUS_STYLE_IN) && BUS_STYLE_IN |-> IRQ_OE_OUT == $past(irq_en_q))
    else $error("irq enable mismatch"); // [R15]
  rw_irq_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    !$past(BUS_STYLE_IN) |-> IRQ_OUT == 4'h0 && IRQ_OE_OUT[3:1] == 3'h7)
    else $error("unused irq pins not low"); // [R16]
endmodule // qubp_port

//--- test/qubp_host.sv
// Host bus master model for the quad channel port
`timescale 1ns/1ns
module qubp_host (
  // Clock and strap
  input  wire logic       clk_in,
  input  wire logic       style_in,
  // Wire level and device drive
  input  wire logic [7:0] bus_in,
  input  wire logic       dev_oe_in,
  // Pins toward the port
  output qubp_pkg::qubp_ctl_t ctl_out,
  output logic [2:0]      addr_out,
  output logic [7:0]      data_out,
  output logic            drive_out
);
  initial begin
    ctl_out = '{1'b1, 1'b1, 4'hF};
    addr_out = 3'h0;
    data_out = 8'h5A;
    drive_out = 1'b0;
  end

  // Holds every access four cycles so reads meet the active minimum
  task automatic access(input logic rd, input logic en, input logic [1:0] ch,
                        input logic [2:0] ofs, input logic [7:0] wd,
                        output logic [7:0] rdat, output logic oe);
    @(posedge clk_in);
    addr_out <= ofs;
    data_out <= wd;
    drive_out <= ~rd;
    if (style_in) begin
      ctl_out <= '{~rd, rd, en ? ~(4'h1 << ch) : 4'hF};
    end else begin
      ctl_out <= '{1'b1, rd, {1'b1, ch, ~en}};
    end
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    rdat = bus_in;
    oe = dev_oe_in;
    @(posedge clk_in);
    ctl_out <= '{1'b1, 1'b1, 4'hF};
    drive_out <= 1'b0;
    // Released bus shows a changing pattern, never the stale byte
    data_out <= ~data_out;
    repeat (2) @(posedge clk_in);
  endtask
endmodule // qubp_host

//--- test/test_qubp_port.sv
// Self-checking bench for the quad channel host bus port
`timescale 1ns/1ns
module test_qubp_port;
  logic                clk;
  logic                nrst;
  logic                style;
  logic [3:0]          rx_push, tx_pop, irq_src, irq, irq_oe, mask;
  logic [7:0]          rx_byte, bus, dout, hdata, rd, wd, last;
  logic [2:0]          rx_tag, addr, o;
  logic                oe, oe_seen, hdrive;
  logic [1:0]          c;
  logic [4:0]          lvl;
  qubp_pkg::qubp_ctl_t ctl;
  logic [7:0]          shadow [4][8];
  int                  errors, samples_checked;

  always #25 clk = ~clk;
  assign bus = (oe && hdrive) ? 8'hXX : (oe ? dout : hdata);

  qubp_port uut (
    .CORE_CLK_IN(clk), .NRST_IN(nrst), .BUS_STYLE_IN(style),
    .HOST_READ_STROBE_N_IN(ctl.rd_n), .HOST_WRITE_STROBE_N_IN(ctl.wr_n),
    .CHAN_A_SELECT_N_IN(ctl.sel_n[0]), .CHAN_B_SELECT_N_IN(ctl.sel_n[1]),
    .CHAN_C_SELECT_N_IN(ctl.sel_n[2]), .CHAN_D_SELECT_N_IN(ctl.sel_n[3]),
    .REG_ADDR_IN(addr), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_OUT(oe),
    .RX_PUSH_IN(rx_push), .RX_BYTE_IN(rx_byte), .RX_TAG_IN(rx_tag),
    .TX_POP_IN(tx_pop), .IRQ_SRC_IN(irq_src), .IRQ_OUT(irq),
    .IRQ_OE_OUT(irq_oe));

  qubp_host host (
    .clk_in(clk), .style_in(style), .bus_in(bus), .dev_oe_in(oe),
    .ctl_out(ctl), .addr_out(addr), .data_out(hdata), .drive_out(hdrive));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h want %h", $time, msg, seen,
               exp);
    end
  endtask

  task automatic close_out();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic rreg(input logic [2:0] ofs);
    host.access(1'b1, 1'b1, c, ofs, 8'h00, rd, oe_seen);
  endtask

  task automatic push();
    @(posedge clk);
    rx_push <= 4'h1 << c;
    last = 8'($urandom);
    rx_byte <= last;
    rx_tag <= 3'($urandom);
    @(posedge clk);
    rx_push <= 4'h0;
  endtask

  function automatic logic [4:0] trig_lvl(input logic [1:0] t);
    case (t)
      2'h0: return qubp_pkg::TRIG_LVL0;
      2'h1: return qubp_pkg::TRIG_LVL1;
      2'h2: return qubp_pkg::TRIG_LVL2;
      default: return qubp_pkg::TRIG_LVL3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    style = 1'b1;
    {rx_push, tx_pop, irq_src, rx_byte, rx_tag} = '0;
    void'($urandom(32'hE4DADA1B));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // Plain registers: strobe style, then read/write style, then strobe
    for (int p = 0; p < 3; p++) begin
      style <= (p != 1);
      for (int ch = 0; ch < 4; ch++) begin
        for (int k = 0; k < 4; k++) begin
          c = 2'(ch);
          o = (k < 2) ? 3'(2 * k + 1) : 3'(k + 4);
          rreg(o);
          check(rd, p == 0 ? qubp_pkg::REG_RST : shadow[c][o], "reg");
          check({7'h00, oe_seen}, 8'h01, "read drive");
          wd = 8'($urandom);
          host.access(1'b0, 1'b1, c, o, wd, rd, oe_seen);
          check({7'h00, oe_seen}, 8'h00, "write drive");
          shadow[c][o] = wd;
        end
      end
    end
    // Unselected accesses change nothing and leave the bus free
    for (int s = 0; s < 2; s++) begin
      style <= s[0];
      c = 2'h2;
      host.access(1'b0, 1'b0, c, 3'h3, ~shadow[2][3], rd, oe_seen);
      host.access(1'b1, 1'b0, c, 3'h3, 8'h00, rd, oe_seen);
      check({7'h00, oe_seen}, 8'h00, "idle drive");
      rreg(3'h3);
      check(rd, shadow[2][3], "unselected write");
    end
    // Interrupt pins in both styles
    for (int s = 1; s >= 0; s--) begin
      style <= s[0];
      mask = 4'($urandom);
      for (int ch = 0; ch < 4; ch++) begin
        wd = 8'h00;
        wd[qubp_pkg::MCTL_IRQ_EN_BIT] = mask[ch];
        host.access(1'b0, 1'b1, 2'(ch), qubp_pkg::OFS_MCTL, wd, rd, oe_seen);
      end
      for (int n = 0; n < 6; n++) begin
        irq_src <= (n == 0) ? 4'h0 : 4'($urandom);
        repeat (3) @(posedge clk);
        @(negedge clk);
        if (s == 1) begin
          check({4'h0, irq_oe}, {4'h0, mask}, "irq enable");
          check({4'h0, irq & mask}, {4'h0, irq_src & mask}, "irq");
        end else begin
          check({4'h0, irq}, 8'h00, "irq level");
          check({4'h0, irq_oe}, {4'h0, 3'h7, |irq_src}, "irq drive");
        end
      end
    end
    // Receive thresholds, every trigger setting
    style <= 1'b1;
    c = 2'($urandom_range(3));
    for (int t = 0; t < 4; t++) begin
      lvl = trig_lvl(2'(t));
      host.access(1'b0, 1'b1, c, qubp_pkg::OFS_FCTL, {2'(t), 6'h00}, rd,
                  oe_seen);
      repeat (int'(lvl) - 1) push();
      rreg(qubp_pkg::OFS_STAT);
      check({7'h00, rd[qubp_pkg::STAT_RXRDY_BIT]}, 8'h00, "below");
      push();
      rreg(qubp_pkg::OFS_STAT);
      check({7'h00, rd[qubp_pkg::STAT_RXRDY_BIT]}, 8'h01, "at lvl");
      rreg(qubp_pkg::OFS_DATA);
      check(rd, last, "rx byte");
      repeat (int'(lvl) - 1) rreg(qubp_pkg::OFS_DATA);
    end
    // Transmit empty flag follows a write and a pop
    rreg(qubp_pkg::OFS_STAT);
    check({7'h00, rd[qubp_pkg::STAT_TXEMP_BIT]}, 8'h01, "tx idle");
    host.access(1'b0, 1'b1, c, qubp_pkg::OFS_DATA, 8'h3C, rd, oe_seen);
    rreg(qubp_pkg::OFS_STAT);
    check({7'h00, rd[qubp_pkg::STAT_TXEMP_BIT]}, 8'h00, "tx held");
    @(posedge clk);
    tx_pop <= 4'h1 << c;
    @(posedge clk);
    tx_pop <= 4'h0;
    rreg(qubp_pkg::OFS_STAT);
    check({7'h00, rd[qubp_pkg::STAT_TXEMP_BIT]}, 8'h01, "tx sent");
    close_out();
  end

  // Roughly twenty-five times the expected run length
  initial begin
    #1500000;
    errors++;
    close_out();
  end
endmodule // test_qubp_port
